/* File: shared/isl_pkg.sv */
// constants shared by the interrupt status latch and its helpers
package isl_pkg;
    // host register map
    localparam int ISL_ADDR_W = 8;
    localparam logic [7:0] ISL_ADDR_FLAGS = 8'h58;
    localparam logic [7:0] ISL_ADDR_BYTE_TEST = 8'h64;
    localparam logic [31:0] ISL_READ_ZERO = 32'h0000_0000;

    // flag positions in the event flag register
    localparam int ISL_BIT_SOFTWARE = 31;
    localparam int ISL_BIT_TX_HALTED = 25;
    localparam int ISL_BIT_RX_HALTED = 24;
    localparam int ISL_BIT_DROP_MID = 23;
    localparam int ISL_BIT_TX_COMPLETION = 21;
    localparam int ISL_BIT_RX_TRANSFER = 20;
    localparam int ISL_BIT_TIMER_WRAP = 19;
    localparam int ISL_BIT_TRANSCEIVER = 18;
    localparam int ISL_BIT_POWER = 17;
    localparam int ISL_BIT_TX_STATUS_OVF = 16;
    localparam int ISL_BIT_RX_OVERSIZE = 15;
    localparam int ISL_BIT_RX_ERROR = 14;
    localparam int ISL_BIT_TX_ERROR = 13;
    localparam int ISL_BIT_TX_UNDERRUN = 11;
    localparam int ISL_BIT_TX_OVERRUN = 10;
    localparam int ISL_BIT_TX_SPACE = 9;
    localparam int ISL_BIT_TX_STATUS_FULL = 8;
    localparam int ISL_BIT_TX_STATUS_LEVEL = 7;
    localparam int ISL_BIT_RX_DROP = 6;
    localparam int ISL_BIT_RX_DATA_LEVEL = 5;
    localparam int ISL_BIT_RX_STATUS_FULL = 4;
    localparam int ISL_BIT_RX_STATUS_LEVEL = 3;
    localparam int ISL_BIT_PIN_LOW = 0;
    localparam int ISL_PIN_COUNT = 3;

    // bits cleared by writing one, and bits that read back
    localparam logic [31:0] ISL_CLEARABLE_MASK = 32'h83BB_EFFF;
    localparam logic [31:0] ISL_READABLE_MASK = 32'h83BF_EFFF;
    localparam logic [31:0] ISL_FLAGS_RESET = 32'h0000_0000;

    // source thresholds
    localparam logic [31:0] ISL_DROP_BEFORE_MID = 32'h7FFF_FFFF;
    localparam logic [31:0] ISL_DROP_AFTER_MID = 32'h8000_0000;
    localparam logic [15:0] ISL_TIMER_FROM = 16'h0000;
    localparam logic [15:0] ISL_TIMER_TO = 16'hFFFF;
    localparam logic [15:0] ISL_OVERSIZE_BYTES = 16'h0800;
    localparam logic [7:0] ISL_COUNT_ZERO = 8'h00;
    localparam logic [7:0] ISL_COUNT_ONE = 8'h01;
endpackage

/* File: rtl/isl_flag_bank.sv */
// bank of sticky write-one-to-clear flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module isl_flag_bank
    import isl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [31:0] set_in,
    input wire logic [31:0] clear_in,
    output logic [31:0] flags_out
);
    typedef struct packed {
        logic [31:0] flags;
    } isl_bank_t;

    isl_bank_t state;
    isl_bank_t next_state;
    logic [31:0] next_bits;

    // one sticky cell per bit
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_cell
            assign next_bits[i] = set_in[i] | (state.flags[i] & ~clear_in[i]);
        end
    endgenerate

    // next state
    always_comb begin
        next_state = state;
        next_state.flags = next_bits;
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state.flags <= ISL_FLAGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign flags_out = state.flags;
endmodule
`default_nettype wire

/* File: rtl/isl_xfer_count.sv */
// counts receive FIFO reads down from the programmed transfer count
`timescale 1ns/1ps
`default_nettype none
module isl_xfer_count
    import isl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire logic [7:0] count_in,
    input wire logic read_in,
    output logic done_out
);
    typedef struct packed {
        logic [7:0] remaining;
        logic done;
    } isl_xfer_t;

    isl_xfer_t state;
    isl_xfer_t next_state;

    // a load restarts the count; the last read pulses done
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (load_in) begin
            next_state.remaining = count_in;
        end else if (read_in && state.remaining != ISL_COUNT_ZERO) begin
            next_state.remaining = state.remaining - ISL_COUNT_ONE;
            next_state.done = (state.remaining == ISL_COUNT_ONE);
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state.remaining <= ISL_COUNT_ZERO;
            state.done <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign done_out = state.done;
endmodule
`default_nettype wire

/* File: rtl/isl_status_latch.sv */
// interrupt event flag register with its event detection and host port
`timescale 1ns/1ps
`default_nettype none
module isl_status_latch
    import isl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    // host register port
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [31:0] host_wdata_in,
    output logic [31:0] host_rdata_out,
    // enable mask held elsewhere
    input wire logic [31:0] irq_enable_mask_in,
    input wire logic software_request_enable_in,
    // transmit and receive engine
    input wire logic stop_tx_request_in,
    input wire logic tx_halted_in,
    input wire logic rx_halted_in,
    input wire logic [31:0] drop_count_in,
    input wire logic tx_buffer_loaded_in,
    input wire logic request_completion_notice_in,
    input wire logic rx_transfer_load_in,
    input wire logic [7:0] receive_transfer_count_in,
    input wire logic rx_fifo_read_in,
    input wire logic [15:0] timer_value_in,
    input wire logic transceiver_event_in,
    input wire logic power_event_in,
    input wire logic tx_status_overflow_in,
    input wire logic rx_packet_done_in,
    input wire logic [15:0] rx_packet_bytes_in,
    input wire logic rx_error_in,
    input wire logic tx_error_in,
    input wire logic tx_data_underrun_in,
    input wire logic tx_data_write_in,
    input wire logic tx_data_full_in,
    input wire logic [7:0] tx_free_blocks_in,
    input wire logic [7:0] tx_space_level_in,
    input wire logic tx_status_full_in,
    input wire logic [7:0] tx_status_used_in,
    input wire logic [7:0] tx_status_level_in,
    input wire logic rx_frame_dropped_in,
    input wire logic [7:0] rx_free_blocks_in,
    input wire logic [7:0] rx_space_level_in,
    input wire logic rx_status_full_in,
    input wire logic [7:0] rx_status_used_in,
    input wire logic [7:0] rx_status_level_in,
    input wire logic [2:0] pin_events_in,
    // results
    output logic [31:0] interrupt_event_flags_out,
    output logic master_irq_out,
    output logic power_irq_out,
    output logic wake_out
);
    typedef struct packed {
        logic [31:0] drop_prev;
        logic [15:0] timer_prev;
        logic transceiver_event_flag;
        logic [31:0] rdata;
        logic master_irq;
        logic power_irq;
        logic wake;
    } isl_main_t;

    isl_main_t state;
    isl_main_t next_state;

    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic [31:0] latched;
    logic [31:0] status_view;
    logic rx_transfer_done;
    logic flags_write;
    logic byte_test_write;

    // decode of host writes
    assign flags_write = host_wr_in && (host_addr_in == ISL_ADDR_FLAGS);
    assign byte_test_write = host_wr_in && (host_addr_in == ISL_ADDR_BYTE_TEST);

    assign clear_vec = flags_write ? (host_wdata_in & ISL_CLEARABLE_MASK) : ISL_READ_ZERO;

    // receive transfer count tracker
    isl_xfer_count u_xfer (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .load_in(rx_transfer_load_in),
        .count_in(receive_transfer_count_in),
        .read_in(rx_fifo_read_in),
        .done_out(rx_transfer_done)
    );

    // event sources gathered into one set vector
    always_comb begin
        set_vec = ISL_READ_ZERO;
        set_vec[ISL_BIT_SOFTWARE] = software_request_enable_in;
        set_vec[ISL_BIT_TX_HALTED] = stop_tx_request_in & tx_halted_in;
        set_vec[ISL_BIT_RX_HALTED] = rx_halted_in;
        set_vec[ISL_BIT_DROP_MID] = (state.drop_prev == ISL_DROP_BEFORE_MID)
            && (drop_count_in == ISL_DROP_AFTER_MID);
        set_vec[ISL_BIT_TX_COMPLETION] = tx_buffer_loaded_in
            & request_completion_notice_in;
        set_vec[ISL_BIT_RX_TRANSFER] = rx_transfer_done;
        set_vec[ISL_BIT_TIMER_WRAP] = (state.timer_prev == ISL_TIMER_FROM)
            && (timer_value_in == ISL_TIMER_TO);
        set_vec[ISL_BIT_POWER] = power_event_in;
        set_vec[ISL_BIT_TX_STATUS_OVF] = tx_status_overflow_in;
        set_vec[ISL_BIT_RX_OVERSIZE] = rx_packet_done_in
            && (rx_packet_bytes_in > ISL_OVERSIZE_BYTES);
        set_vec[ISL_BIT_RX_ERROR] = rx_error_in;
        set_vec[ISL_BIT_TX_ERROR] = tx_error_in;
        set_vec[ISL_BIT_TX_UNDERRUN] = tx_data_underrun_in;
        set_vec[ISL_BIT_TX_OVERRUN] = tx_data_write_in & tx_data_full_in;
        set_vec[ISL_BIT_TX_SPACE] = tx_free_blocks_in > tx_space_level_in;
        set_vec[ISL_BIT_TX_STATUS_FULL] = tx_status_full_in;
        set_vec[ISL_BIT_RX_STATUS_FULL] = rx_status_full_in;
        set_vec[ISL_BIT_TX_STATUS_LEVEL] = tx_status_used_in > tx_status_level_in;
        set_vec[ISL_BIT_RX_DATA_LEVEL] = rx_free_blocks_in < rx_space_level_in;
        set_vec[ISL_BIT_RX_STATUS_LEVEL] = rx_status_used_in > rx_status_level_in;
        set_vec[ISL_BIT_RX_DROP] = rx_frame_dropped_in;
        set_vec[ISL_BIT_PIN_LOW +: ISL_PIN_COUNT] = pin_events_in;
    end

    // sticky flags; reserved bits are never set so they stay zero
    isl_flag_bank u_bank (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .set_in(set_vec & ISL_CLEARABLE_MASK),
        .clear_in(clear_vec),
        .flags_out(latched)
    );

    // register view: latched flags plus the registered transceiver level
    always_comb begin
        status_view = latched;
        status_view[ISL_BIT_TRANSCEIVER] = state.transceiver_event_flag;
        status_view = status_view & ISL_READABLE_MASK;
    end

    // next state of the main block
    always_comb begin
        next_state = state;
        // history for the step detectors, and the registered transceiver level
        next_state.drop_prev = drop_count_in;
        next_state.timer_prev = timer_value_in;
        next_state.transceiver_event_flag = transceiver_event_in;
        // register read answer, unmapped reads return zero
        if (host_rd_in) begin
            if (host_addr_in == ISL_ADDR_FLAGS) begin
                next_state.rdata = status_view;
            end else begin
                next_state.rdata = ISL_READ_ZERO;
            end
        end
        next_state.master_irq = |(status_view & irq_enable_mask_in);
        next_state.power_irq = status_view[ISL_BIT_POWER]
            & irq_enable_mask_in[ISL_BIT_POWER];
        next_state.wake = byte_test_write;
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state.drop_prev <= ISL_READ_ZERO;
            // parked at the wrap target so a timer at FFFFh after reset is no false wrap
            state.timer_prev <= ISL_TIMER_TO;
            state.transceiver_event_flag <= 1'b0;
            state.rdata <= ISL_READ_ZERO;
            state.master_irq <= 1'b0;
            state.power_irq <= 1'b0;
            state.wake <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // outputs come straight from flops
    assign host_rdata_out = state.rdata;
    assign interrupt_event_flags_out = latched;
    assign master_irq_out = state.master_irq;
    assign power_irq_out = state.power_irq;
    assign wake_out = state.wake;
endmodule
`default_nettype wire

/* File: bench/isl_status_latch_assertions.sv */
// port-level checks of the interrupt event flag register
`timescale 1ns/1ps
`default_nettype none
module isl_status_latch_checker
    import isl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [31:0] host_wdata_in,
    input wire logic [31:0] host_rdata_out,
    input wire logic [31:0] irq_enable_mask_in,
    input wire logic software_request_enable_in,
    input wire logic rx_halted_in,
    input wire logic [31:0] interrupt_event_flags_out,
    input wire logic master_irq_out,
    input wire logic power_irq_out,
    input wire logic wake_out
);
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    a_software_set: assert property (
        software_request_enable_in |-> ##[1:2] interrupt_event_flags_out[31])
        else $error("software flag not set");
    a_software_clear: assert property (
        !software_request_enable_in ##1 (host_wr_in && host_addr_in == ISL_ADDR_FLAGS
        && host_wdata_in[31] && !software_request_enable_in) ##1 !software_request_enable_in
        |=> !interrupt_event_flags_out[31])
        else $error("software flag not cleared");
    a_reserved_zero: assert property (
        (interrupt_event_flags_out & ~ISL_CLEARABLE_MASK) == 32'h0
        && (host_rdata_out & ~ISL_READABLE_MASK) == 32'h0)
        else $error("reserved bit set");
    a_read_value: assert property (
        host_rd_in && host_addr_in == ISL_ADDR_FLAGS
        |=> (host_rdata_out & ISL_CLEARABLE_MASK) == $past(interrupt_event_flags_out))
        else $error("read data differs from flags");
    a_rx_halt_set: assert property (
        rx_halted_in |-> ##[1:2] interrupt_event_flags_out[24])
        else $error("receive halt flag not set");
    a_master_level: assert property (
        !$past(irq_enable_mask_in[18]) |-> master_irq_out
        == |($past(interrupt_event_flags_out) & $past(irq_enable_mask_in)))
        else $error("master interrupt wrong");
    a_power_level: assert property (
        power_irq_out == ($past(interrupt_event_flags_out[17]) && $past(irq_enable_mask_in[17])))
        else $error("power interrupt wrong");
    a_wake_cause: assert property (
        host_wr_in && host_addr_in == ISL_ADDR_BYTE_TEST |=> wake_out)
        else $error("wake missing");
    a_wake_only: assert property (
        wake_out |-> $past(host_wr_in) && $past(host_addr_in) == ISL_ADDR_BYTE_TEST)
        else $error("wake without byte test write");
endmodule
bind isl_status_latch isl_status_latch_checker u_checker (
    .mclk_in, .reset_in, .host_wr_in, .host_rd_in, .host_addr_in, .host_wdata_in,
    .host_rdata_out, .irq_enable_mask_in, .software_request_enable_in, .rx_halted_in,
    .interrupt_event_flags_out, .master_irq_out, .power_irq_out, .wake_out
);
`default_nettype wire

/* File: bench/isl_host_model.sv */
// host processor model driving the register port with one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module isl_host_model (
    input wire logic mclk_in,
    input wire logic [31:0] host_rdata_in,
    output logic host_wr_out,
    output logic host_rd_out,
    output logic [7:0] host_addr_out,
    output logic [31:0] host_wdata_out
);
    // idle bus with both strobes low
    initial begin
        host_wr_out = 1'b0;
        host_rd_out = 1'b0;
        host_addr_out = 8'h00;
        host_wdata_out = 32'h0;
    end
    // write held across one rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_addr_out = a;
        host_wdata_out = d;
        host_wr_out = 1'b1;
        @(negedge mclk_in);
        host_wr_out = 1'b0;
    endtask
    // read, data taken once the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host_addr_out = a;
        host_rd_out = 1'b1;
        @(negedge mclk_in);
        host_rd_out = 1'b0;
        @(negedge mclk_in);
        d = host_rdata_in;
    endtask
endmodule
`default_nettype wire

/* File: bench/test_isl_status_latch.sv */
// self-checking bench for the interrupt status latch
`timescale 1ns/1ps
`default_nettype none
module test_isl_status_latch
    import isl_pkg::*;
;
    localparam logic [63:0] QUIET = 64'h0000_00FF_0000_0000;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr, rd, mst, pwr, wake;
    logic [7:0] addr, cnt;
    logic [31:0] wdata, rdata, flags, mask, drop;
    logic [22:0] ev;
    logic [63:0] lv;
    logic [15:0] tmr, pk;
    int n_fail = 0;
    int total_checks = 0;
    int n_wake = 0;

    isl_host_model host (.mclk_in, .host_rdata_in(rdata), .host_wr_out(wr), .host_rd_out(rd),
        .host_addr_out(addr), .host_wdata_out(wdata));
    isl_status_latch dut (.mclk_in, .reset_in, .host_wr_in(wr), .host_rd_in(rd),
        .host_addr_in(addr), .host_wdata_in(wdata), .host_rdata_out(rdata),
        .irq_enable_mask_in(mask), .software_request_enable_in(ev[0]),
        .stop_tx_request_in(ev[1]), .tx_halted_in(ev[2]), .rx_halted_in(ev[3]),
        .drop_count_in(drop), .tx_buffer_loaded_in(ev[4]),
        .request_completion_notice_in(ev[5]), .rx_transfer_load_in(ev[22]),
        .receive_transfer_count_in(cnt), .rx_fifo_read_in(ev[21]), .timer_value_in(tmr),
        .transceiver_event_in(ev[6]), .power_event_in(ev[7]), .tx_status_overflow_in(ev[8]),
        .rx_packet_done_in(ev[20]), .rx_packet_bytes_in(pk), .rx_error_in(ev[9]),
        .tx_error_in(ev[10]), .tx_data_underrun_in(ev[11]), .tx_data_write_in(ev[12]),
        .tx_data_full_in(ev[13]), .tx_free_blocks_in(lv[7:0]), .tx_space_level_in(lv[15:8]),
        .tx_status_full_in(ev[14]), .tx_status_used_in(lv[23:16]),
        .tx_status_level_in(lv[31:24]), .rx_frame_dropped_in(ev[15]),
        .rx_free_blocks_in(lv[39:32]), .rx_space_level_in(lv[47:40]),
        .rx_status_full_in(ev[16]), .rx_status_used_in(lv[55:48]),
        .rx_status_level_in(lv[63:56]), .pin_events_in(ev[19:17]),
        .interrupt_event_flags_out(flags), .master_irq_out(mst), .power_irq_out(pwr),
        .wake_out(wake));

    // free-running clock and wake pulse counter
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(negedge mclk_in) begin
        if (wake === 1'b1) n_wake++;
    end

    // flags expected after one pulse of events and levels
    function automatic logic [31:0] exp_f(input logic [22:0] e, input logic [63:0] l,
        input logic [15:0] b);
        return {e[0], 5'h0, e[1] & e[2], e[3], 2'h0, e[4] & e[5], 3'h0, e[7], e[8],
            e[20] && b > ISL_OVERSIZE_BYTES, e[9], e[10], 1'b0, e[11], e[12] & e[13],
            l[7:0] > l[15:8], e[14], l[23:16] > l[31:24], e[15], l[39:32] < l[47:40],
            e[16], l[55:48] > l[63:56], e[19:17]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung sequence
    initial begin
        #200000;
        n_fail++;
        complete_run;
    end

    // main sequence
    initial begin
        logic [22:0] e;
        logic [31:0] x, m, got;
        ev = '0;
        lv = QUIET;
        drop = 32'h0;
        tmr = 16'h1234;
        pk = 16'h0;
        cnt = 8'h0;
        mask = 32'h0;
        void'($urandom(32'h794B));
        repeat (6) @(negedge mclk_in);
        reset_in = 1'b0;
        chk(flags, ISL_FLAGS_RESET);
        chk(rdata, ISL_READ_ZERO);
        chk({29'h0, mst, pwr, wake}, 32'h0);
        for (int i = 0; i < 40; i++) begin
            e = (i < 20) ? 23'h1 << i : 23'($urandom());
            e = e & 23'h1F_FFBF;
            mask = $urandom() & 32'hFFFB_FFFF;
            pk = ISL_OVERSIZE_BYTES - 16'h1 + 16'(i % 3);
            @(negedge mclk_in);
            ev = e;
            lv = {$urandom(), $urandom()};
            x = exp_f(e, lv, pk);
            if ($urandom_range(1, 0) == 1) host.wr(ISL_ADDR_FLAGS, 32'hFFFF_FFFF);
            else @(negedge mclk_in);
            ev = '0;
            lv = QUIET;
            repeat (3) @(negedge mclk_in);
            chk(flags, x);
            chk({31'h0, mst}, {31'h0, |(x & mask)});
            chk({31'h0, pwr}, {31'h0, x[17] & mask[17]});
            m = $urandom();
            host.wr(ISL_ADDR_FLAGS, m);
            host.rd(ISL_ADDR_FLAGS, got);
            chk(got, x & ~m);
            host.wr(ISL_ADDR_FLAGS, 32'hFFFF_FFFF);
        end
        // counter midpoint and timer wrap, with near misses first
        drop = 32'h7FFF_FFFE;
        tmr = 16'h0001;
        @(negedge mclk_in);
        drop = ISL_DROP_BEFORE_MID;
        tmr = ISL_TIMER_FROM;
        @(negedge mclk_in);
        drop = ISL_DROP_AFTER_MID;
        tmr = ISL_TIMER_TO;
        repeat (3) @(negedge mclk_in);
        chk(flags & 32'h0080_0000, 32'h0080_0000);
        chk(flags & 32'hFF7F_FFFF, 32'h0008_0000);
        host.wr(ISL_ADDR_FLAGS, 32'hFFFF_FFFF);
        // transceiver level is read-only and survives a clearing write
        ev = 23'h40;
        repeat (2) @(negedge mclk_in);
        host.wr(ISL_ADDR_FLAGS, 32'hFFFF_FFFF);
        host.rd(ISL_ADDR_FLAGS, got);
        chk(got, 32'h0004_0000);
        chk(flags, 32'h0);
        // transfer count: no flag one read short, flag after the last read
        cnt = 8'($urandom_range(4, 1));
        ev = 23'h40_0000;
        @(negedge mclk_in);
        ev = '0;
        repeat (cnt - 8'h1) begin
            @(negedge mclk_in);
            ev = 23'h20_0000;
            @(negedge mclk_in);
            ev = '0;
        end
        repeat (3) @(negedge mclk_in);
        chk(flags, 32'h0);
        ev = 23'h20_0000;
        @(negedge mclk_in);
        ev = '0;
        repeat (3) @(negedge mclk_in);
        chk(flags, 32'h0010_0000);
        host.wr(ISL_ADDR_FLAGS, 32'hFFFF_FFFF);
        // byte-test write wakes, other addresses read zero
        @(negedge mclk_in);
        host.wr(ISL_ADDR_BYTE_TEST, $urandom());
        host.rd(8'h5C, got);
        chk(got, ISL_READ_ZERO);
        chk(n_wake, 32'h1);
        chk(flags, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
